// ===== design/dtm_pkg.sv
// dtm_pkg: constants and types shared by the dual timer block
// assumes: an 8-bit special-function register port driven by the core
package dtm_pkg;

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_TIMER_CONTROL  = 8'h88;
    localparam logic [7:0] ADDR_TIMER_MODE     = 8'h89;
    localparam logic [7:0] ADDR_T0_LOW         = 8'h8a;
    localparam logic [7:0] ADDR_T1_LOW         = 8'h8b;
    localparam logic [7:0] ADDR_T0_HIGH        = 8'h8c;
    localparam logic [7:0] ADDR_T1_HIGH        = 8'h8d;
    localparam logic [7:0] ADDR_THIRD_CONTROL  = 8'hc8;
    localparam logic [7:0] ADDR_RELOAD_LOW     = 8'hca;
    localparam logic [7:0] ADDR_RELOAD_HIGH    = 8'hcb;
    localparam logic [7:0] ADDR_T2_LOW         = 8'hcc;
    localparam logic [7:0] ADDR_T2_HIGH        = 8'hcd;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    // timer_control_reg
    localparam int TCB_FLAG_ONE  = 7;
    localparam int TCB_RUN_ONE   = 6;
    localparam int TCB_FLAG_ZERO = 5;
    localparam int TCB_RUN_ZERO  = 4;
    // timer_mode_reg: each timer owns one nibble
    localparam int TMB_GATE      = 3;
    localparam int TMB_COUNT_SEL = 2;
    localparam int TMB_MODE_HI   = 1;
    localparam int TMB_NIB_ONE   = 4;
    // third_timer_control_reg
    localparam int T2B_OVF_FLAG  = 7;
    localparam int T2B_EXT_FLAG  = 6;
    localparam int T2B_RX_CLK    = 5;
    localparam int T2B_TX_CLK    = 4;
    localparam int T2B_EXT_EN    = 3;
    localparam int T2B_RUN       = 2;
    localparam int T2B_COUNT_SEL = 1;
    localparam int T2B_CAPTURE   = 0;

    // ------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------
    localparam logic [7:0] RESET_BYTE  = 8'h00;
    localparam logic [3:0] MCYC_CLOCKS = 4'hc;   // clocks per machine cycle

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {MODE_13BIT, MODE_16BIT, MODE_RELOAD8, MODE_SPLIT} dtm_t01_mode_e;
    typedef enum logic [1:0] {T2_OFF, T2_RELOAD, T2_CAPTURE, T2_BAUD} dtm_t2_mode_e;

    typedef struct packed {
        logic external_trigger_pin;
        logic t2_count_pin;
        logic t1_count_pin;
        logic t0_count_pin;
        logic external_gate_pin_one;
        logic external_gate_pin_zero;
    } dtm_pins_s;

    typedef struct packed {
        logic [7:0] th;
        logic [7:0] tl;
        logic       ovf;
    } dtm_step_s;

endpackage

// ===== design/dtm_timer.sv
// dtm_timer: timers 0 and 1 (four modes each) plus timer 2 (reload, capture, baud)
// assumes: core drives the sfr port on REF_CLK; pins are asynchronous to REF_CLK
//
// Behaviour
// RULE1 - mode 0 count is high byte plus low five bits of low byte
// RULE2 - wrap from all ones to zero sets that timer's overflow flag
// RULE3 - count only when run bit set and gate off or gate pin high
// RULE4 - setting run bit never clears the count bytes
// RULE5 - mode 1 behaves like mode 0 but uses all sixteen bits
// RULE6 - mode 2 low byte counts, reloads from high byte on overflow, flag set
// RULE7 - timer 1 in split mode holds its count as if stopped
// RULE8 - split: t0 low byte uses t0 controls, high byte uses t1 run/flag
// RULE9 - with t0 split, t1 runs outside split mode, no own flag
// RULE10 - timer 2 mode from run bit, clock selects and capture select
// RULE11 - timer 2 reload mode: rollover sets flag and reloads 16 bits
// RULE12 - reload mode with external enable: trigger pin fall reloads, sets ext flag
// RULE13 - capture mode: counter runs freely, overflow sets flag
// RULE14 - capture mode with external enable: pin fall captures count, sets ext flag
// RULE15 - baud mode never sets overflow flag; ext flag still works
// RULE16 - t0/t1 flags set on overflow, cleared on interrupt vector
// RULE17 - software sets run bit to start a timer, clears it to stop
// RULE18 - count select picks machine cycles or count-pin falling edges
`timescale 1ns/100ps
module dtm_timer
    import dtm_pkg::*;
(
    input  wire logic              REF_CLK,
    input  wire logic              RST,
    input  wire logic [7:0]        SFR_ADDR,
    input  wire logic              SFR_WR,
    input  wire logic [7:0]        SFR_WDATA,
    input  wire logic              SFR_RD,
    output logic      [7:0]        SFR_RDATA,
    input  wire dtm_pkg::dtm_pins_s PINS,
    input  wire logic              ACK_FLAG_ZERO,
    input  wire logic              ACK_FLAG_ONE,
    output logic                   OVERFLOW_FLAG_ZERO,
    output logic                   OVERFLOW_FLAG_ONE,
    output logic                   OVERFLOW_FLAG_TWO,
    output logic                   EXTERNAL_FLAG_TWO,
    output logic                   T1_OVF_PULSE,
    output logic                   T2_OVF_PULSE
);
    import dtm_pkg::*;

    // ------------------------------------------------------------
    // one counting step for a timer 0/1 byte pair
    // ------------------------------------------------------------
    function automatic dtm_step_s tmr_step(dtm_t01_mode_e mode, logic [7:0] th, logic [7:0] tl, logic inc);
        dtm_step_s  r;
        logic [12:0] c13;
        logic [15:0] c16;
        r     = '{th: th, tl: tl, ovf: 1'b0};
        c13   = {th, tl[4:0]} + 13'h0001;
        c16   = {th, tl} + 16'h0001;
        if (inc) begin
            case (mode)
                MODE_13BIT: begin
                    // upper three low-byte bits are left alone
                    r.ovf = &{th, tl[4:0]};            // [RULE1] [RULE2]
                    r.th  = c13[12:5];
                    r.tl  = {tl[7:5], c13[4:0]};
                end
                MODE_16BIT: begin
                    r.ovf = &{th, tl};                 // [RULE5] [RULE2]
                    r.th  = c16[15:8];
                    r.tl  = c16[7:0];
                end
                MODE_RELOAD8: begin
                    r.ovf = &tl;                       // [RULE6]
                    r.tl  = (&tl) ? th : tl + 8'h01;   // [RULE6]
                end
                default: begin
                    // split: only the low byte counts here
                    r.ovf = &tl;
                    r.tl  = tl + 8'h01;
                end
            endcase
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers and falling-edge detect
    // ------------------------------------------------------------
    logic [5:0] s1_q, s2_q, s3_q, filt_q, filt_prev_q;
    logic [5:0] fall;
    dtm_pins_s  pin_f;

    // three stages; a level is accepted once stages two and three agree
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            s1_q        <= 6'h3f;
            s2_q        <= 6'h3f;
            s3_q        <= 6'h3f;
            filt_q      <= 6'h3f;
            filt_prev_q <= 6'h3f;
        end else begin
            s1_q        <= PINS;
            s2_q        <= s1_q;
            s3_q        <= s2_q;
            filt_q      <= (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
            filt_prev_q <= filt_q;
        end
    end

    assign fall  = filt_prev_q & ~filt_q;
    assign pin_f = dtm_pins_s'(filt_q);

    // ------------------------------------------------------------
    // machine cycle tick
    // ------------------------------------------------------------
    logic [3:0] mcyc_q;
    logic       tick;

    // one tick every machine cycle
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            mcyc_q <= 4'h0;
        end else begin
            mcyc_q <= (mcyc_q == MCYC_CLOCKS - 4'h1) ? 4'h0 : mcyc_q + 4'h1;
        end
    end

    assign tick = (mcyc_q == MCYC_CLOCKS - 4'h1);

    // ------------------------------------------------------------
    // software-visible registers
    // ------------------------------------------------------------
    logic [7:0]    timer_mode_reg_q;
    logic          run0_q, run1_q, flag0_q, flag1_q;
    logic [7:0]    th0_q, tl0_q, th1_q, tl1_q;
    logic [7:0]    t2ctl_q;      // run, selects and enables; flags kept apart
    logic          tf2_q, external_flag_two_q;
    logic [7:0]    rcap_lo_q, rcap_hi_q, th2_q, tl2_q;
    logic          wr_ctl, wr_t2ctl;

    assign wr_ctl   = SFR_WR && (SFR_ADDR == ADDR_TIMER_CONTROL);
    assign wr_t2ctl = SFR_WR && (SFR_ADDR == ADDR_THIRD_CONTROL);

    // mode and run bits only change by software
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            timer_mode_reg_q  <= RESET_BYTE;
            run0_q  <= 1'b0;
            run1_q  <= 1'b0;
            t2ctl_q <= RESET_BYTE;
        end else begin
            if (SFR_WR && SFR_ADDR == ADDR_TIMER_MODE) begin
                timer_mode_reg_q <= SFR_WDATA;
            end
            if (wr_ctl) begin
                // run bits start/stop only; counts untouched  [RULE4]
                run0_q <= SFR_WDATA[TCB_RUN_ZERO];
                run1_q <= SFR_WDATA[TCB_RUN_ONE];
            end
            if (wr_t2ctl) begin
                t2ctl_q <= SFR_WDATA;
            end
        end
    end

    // ------------------------------------------------------------
    // timer 0 and 1 counting
    // ------------------------------------------------------------
    dtm_t01_mode_e mode0, mode1;
    logic          gate0_ok, gate1_ok, inc0, inc1, inc0_hi;
    dtm_step_s     st0, st1;
    logic          ovf0_hi, ovf1, set_flag0, set_flag1;

    assign mode0    = dtm_t01_mode_e'(timer_mode_reg_q[TMB_MODE_HI -: 2]);
    assign mode1    = dtm_t01_mode_e'(timer_mode_reg_q[TMB_NIB_ONE + TMB_MODE_HI -: 2]);
    assign gate0_ok = ~timer_mode_reg_q[TMB_GATE] | pin_f.external_gate_pin_zero;                // [RULE3]
    assign gate1_ok = ~timer_mode_reg_q[TMB_NIB_ONE + TMB_GATE] | pin_f.external_gate_pin_one;  // [RULE3]

    // source select: machine cycles or pin falling edges  [RULE18]
    assign inc0 = run0_q & gate0_ok & (timer_mode_reg_q[TMB_COUNT_SEL] ? fall[2] : tick);        // [RULE3] [RULE8]
    // with timer 0 split, timer 1 loses its run bit and runs unless itself split
    assign inc1 = (mode0 == MODE_SPLIT ? 1'b1 : run1_q) & gate1_ok & (mode1 != MODE_SPLIT)
                  & (timer_mode_reg_q[TMB_NIB_ONE + TMB_COUNT_SEL] ? fall[3] : tick);            // [RULE7] [RULE9]
    // split high byte counts machine cycles under timer 1's run bit
    assign inc0_hi = (mode0 == MODE_SPLIT) & run1_q & tick;                            // [RULE8]

    assign st0     = tmr_step(mode0, th0_q, tl0_q, inc0);
    assign st1     = tmr_step(mode1, th1_q, tl1_q, inc1);
    assign ovf0_hi = inc0_hi & (&th0_q);
    assign ovf1    = st1.ovf;

    // flag one belongs to the split high byte while timer 0 is split
    assign set_flag0 = st0.ovf;                                                        // [RULE2]
    assign set_flag1 = (mode0 == MODE_SPLIT) ? ovf0_hi : ovf1;                         // [RULE8] [RULE9]

    // count bytes; a software write wins over a count in the same cycle
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            th0_q <= RESET_BYTE;
            tl0_q <= RESET_BYTE;
            th1_q <= RESET_BYTE;
            tl1_q <= RESET_BYTE;
        end else begin
            tl0_q <= (SFR_WR && SFR_ADDR == ADDR_T0_LOW) ? SFR_WDATA : st0.tl;
            if (SFR_WR && SFR_ADDR == ADDR_T0_HIGH) begin
                th0_q <= SFR_WDATA;
            end else if (mode0 == MODE_SPLIT) begin
                th0_q <= inc0_hi ? th0_q + 8'h01 : th0_q;                              // [RULE8]
            end else begin
                th0_q <= st0.th;
            end
            tl1_q <= (SFR_WR && SFR_ADDR == ADDR_T1_LOW) ? SFR_WDATA : st1.tl;
            th1_q <= (SFR_WR && SFR_ADDR == ADDR_T1_HIGH) ? SFR_WDATA : st1.th;
        end
    end

    // overflow flags: hardware set beats software write or vector clear
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            flag0_q <= 1'b0;
            flag1_q <= 1'b0;
        end else begin
            if (set_flag0) begin
                flag0_q <= 1'b1;                                                       // [RULE16]
            end else if (ACK_FLAG_ZERO) begin
                flag0_q <= 1'b0;                                                       // [RULE16]
            end else if (wr_ctl) begin
                flag0_q <= SFR_WDATA[TCB_FLAG_ZERO];
            end
            if (set_flag1) begin
                flag1_q <= 1'b1;                                                       // [RULE16]
            end else if (ACK_FLAG_ONE) begin
                flag1_q <= 1'b0;                                                       // [RULE16]
            end else if (wr_ctl) begin
                flag1_q <= SFR_WDATA[TCB_FLAG_ONE];
            end
        end
    end

    // ------------------------------------------------------------
    // timer 2
    // ------------------------------------------------------------
    dtm_t2_mode_e mode2;
    logic         inc2, ovf2, ext_ev, do_reload, do_capture;
    logic [15:0]  cnt2_inc;

    // mode decode from run, clock selects and capture select
    always_comb begin
        if (!t2ctl_q[T2B_RUN]) begin
            mode2 = T2_OFF;                                                            // [RULE10]
        end else if (t2ctl_q[T2B_RX_CLK] | t2ctl_q[T2B_TX_CLK]) begin
            mode2 = T2_BAUD;                                                           // [RULE10]
        end else if (t2ctl_q[T2B_CAPTURE]) begin
            mode2 = T2_CAPTURE;                                                        // [RULE10]
        end else begin
            mode2 = T2_RELOAD;                                                         // [RULE10]
        end
    end

    assign inc2       = (mode2 != T2_OFF) & (t2ctl_q[T2B_COUNT_SEL] ? fall[4] : tick);
    assign cnt2_inc   = {th2_q, tl2_q} + 16'h0001;
    assign ovf2       = inc2 & (&{th2_q, tl2_q});
    // external trigger only acts while the timer is on and enabled
    assign ext_ev     = (mode2 != T2_OFF) & t2ctl_q[T2B_EXT_EN] & fall[5];
    // overflow reloads in reload and baud modes; capture mode runs free
    assign do_reload  = (ovf2 & (mode2 != T2_CAPTURE))
                        | (ext_ev & (mode2 == T2_RELOAD));                             // [RULE11] [RULE12] [RULE13]
    assign do_capture = ext_ev & (mode2 == T2_CAPTURE);                                // [RULE14]

    // counter: reload > software write > increment
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            th2_q <= RESET_BYTE;
            tl2_q <= RESET_BYTE;
        end else if (do_reload) begin
            th2_q <= rcap_hi_q;                                                        // [RULE11] [RULE12]
            tl2_q <= rcap_lo_q;
        end else begin
            tl2_q <= (SFR_WR && SFR_ADDR == ADDR_T2_LOW) ? SFR_WDATA : (inc2 ? cnt2_inc[7:0] : tl2_q);
            th2_q <= (SFR_WR && SFR_ADDR == ADDR_T2_HIGH) ? SFR_WDATA : (inc2 ? cnt2_inc[15:8] : th2_q);
        end
    end

    // reload/capture bytes; a capture beats a software write
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            rcap_lo_q <= RESET_BYTE;
            rcap_hi_q <= RESET_BYTE;
        end else if (do_capture) begin
            rcap_lo_q <= tl2_q;                                                        // [RULE14]
            rcap_hi_q <= th2_q;
        end else begin
            if (SFR_WR && SFR_ADDR == ADDR_RELOAD_LOW) begin
                rcap_lo_q <= SFR_WDATA;
            end
            if (SFR_WR && SFR_ADDR == ADDR_RELOAD_HIGH) begin
                rcap_hi_q <= SFR_WDATA;
            end
        end
    end

    // timer 2 flags are cleared by software only; set wins
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            tf2_q  <= 1'b0;
            external_flag_two_q <= 1'b0;
        end else begin
            if (ovf2 && mode2 != T2_BAUD) begin
                tf2_q <= 1'b1;                                                         // [RULE11] [RULE13] [RULE15]
            end else if (wr_t2ctl) begin
                tf2_q <= SFR_WDATA[T2B_OVF_FLAG];
            end
            if (ext_ev) begin
                external_flag_two_q <= 1'b1;                                                        // [RULE12] [RULE14] [RULE15]
            end else if (wr_t2ctl) begin
                external_flag_two_q <= SFR_WDATA[T2B_EXT_FLAG];
            end
        end
    end

    // ------------------------------------------------------------
    // outputs and read port
    // ------------------------------------------------------------
    logic [7:0] rd_mux;

    // unmapped addresses and external-interrupt bits read as zero
    always_comb begin
        case (SFR_ADDR)
            ADDR_TIMER_CONTROL: rd_mux = {flag1_q, run1_q, flag0_q, run0_q, 4'h0};
            ADDR_TIMER_MODE:    rd_mux = timer_mode_reg_q;
            ADDR_T0_LOW:        rd_mux = tl0_q;
            ADDR_T1_LOW:        rd_mux = tl1_q;
            ADDR_T0_HIGH:       rd_mux = th0_q;
            ADDR_T1_HIGH:       rd_mux = th1_q;
            ADDR_THIRD_CONTROL: rd_mux = {tf2_q, external_flag_two_q, t2ctl_q[5:0]};
            ADDR_RELOAD_LOW:    rd_mux = rcap_lo_q;
            ADDR_RELOAD_HIGH:   rd_mux = rcap_hi_q;
            ADDR_T2_LOW:        rd_mux = tl2_q;
            ADDR_T2_HIGH:       rd_mux = th2_q;
            default:            rd_mux = 8'h00;
        endcase
    end

    // read data registered on the read strobe, held until the next read
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            SFR_RDATA <= 8'h00;
        end else if (SFR_RD) begin
            SFR_RDATA <= rd_mux;
        end
    end

    // baud pulses for the serial port; timer 1 keeps pulsing even when split steals its flag
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            T1_OVF_PULSE <= 1'b0;
            T2_OVF_PULSE <= 1'b0;
        end else begin
            T1_OVF_PULSE <= ovf1;                                                      // [RULE9]
            T2_OVF_PULSE <= ovf2;
        end
    end

    assign OVERFLOW_FLAG_ZERO = flag0_q;
    assign OVERFLOW_FLAG_ONE  = flag1_q;
    assign OVERFLOW_FLAG_TWO  = tf2_q;
    assign EXTERNAL_FLAG_TWO  = external_flag_two_q;

endmodule // dtm_timer

// ===== dv/dtm_timer_sva.sv
// dtm_timer_sva: port-level checks for the dual timer block
// assumes: bound into dtm_timer; mode bits mirrored from port writes
`timescale 1ns/100ps
module dtm_timer_sva
    import dtm_pkg::*;
(
    input wire logic       REF_CLK,
    input wire logic       RST,
    input wire logic [7:0] SFR_ADDR,
    input wire logic       SFR_WR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic       SFR_RD,
    input wire logic [7:0] SFR_RDATA,
    input wire logic       ACK_FLAG_ZERO,
    input wire logic       ACK_FLAG_ONE,
    input wire logic       OVERFLOW_FLAG_ZERO,
    input wire logic       OVERFLOW_FLAG_ONE,
    input wire logic       OVERFLOW_FLAG_TWO,
    input wire logic       EXTERNAL_FLAG_TWO,
    input wire logic       T1_OVF_PULSE,
    input wire logic       T2_OVF_PULSE
);
    // ----------------------------------------
    // mode mirrors
    // ----------------------------------------
    logic [7:0] timer_mode_reg_q;
    logic [7:0] t2c_q;
    logic       wr_tc;
    logic       wr_t2;
    logic       baud;
    // hardware never touches mode bits, so a write mirror is exact
    assign wr_tc = SFR_WR && (SFR_ADDR == ADDR_TIMER_CONTROL);
    assign wr_t2 = SFR_WR && (SFR_ADDR == ADDR_THIRD_CONTROL);
    assign baud  = t2c_q[T2B_RX_CLK] || t2c_q[T2B_TX_CLK];
    always_ff @(posedge REF_CLK) begin
        if (RST) timer_mode_reg_q <= 8'h00;
        else if (SFR_WR && (SFR_ADDR == ADDR_TIMER_MODE)) timer_mode_reg_q <= SFR_WDATA;
    end
    always_ff @(posedge REF_CLK) begin
        if (RST) t2c_q <= 8'h00;
        else if (wr_t2) t2c_q <= SFR_WDATA;
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    a_rdata_hold:
        assert property (!SFR_RD |=> $stable(SFR_RDATA)) else $error("read data moved without a read");
    a_unmapped_zero:
        assert property (SFR_RD && !(SFR_ADDR inside {8'h88, [8'h89:8'h8d], 8'hc8, [8'hca:8'hcd]})
            |=> SFR_RDATA == 8'h00) else $error("unmapped read not zero");
    a_flag0_hold:
        assert property (OVERFLOW_FLAG_ZERO && !ACK_FLAG_ZERO && !wr_tc |=> OVERFLOW_FLAG_ZERO)
            else $error("flag zero dropped");
    a_flag1_hold:
        assert property (OVERFLOW_FLAG_ONE && !ACK_FLAG_ONE && !wr_tc |=> OVERFLOW_FLAG_ONE)
            else $error("flag one dropped");
    a_ovf1_flag:
        assert property (T1_OVF_PULSE && timer_mode_reg_q[1:0] != 2'b11
            |-> OVERFLOW_FLAG_ONE || $past(ACK_FLAG_ONE) || $past(wr_tc)) else $error("t1 wrap left flag low");
    a_ovf2_flag:
        assert property (T2_OVF_PULSE && !baud |-> OVERFLOW_FLAG_TWO || $past(wr_t2))
            else $error("t2 wrap left flag low");
    a_flag2_hold:
        assert property (OVERFLOW_FLAG_TWO && !wr_t2 |=> OVERFLOW_FLAG_TWO) else $error("flag two dropped");
    a_baud_noflag:
        assert property (baud && !$past(wr_t2) |-> !$rose(OVERFLOW_FLAG_TWO)) else $error("baud set flag two");
    a_t2off_noext:
        assert property (!t2c_q[T2B_RUN] && !$past(wr_t2) |-> !$rose(EXTERNAL_FLAG_TWO))
            else $error("ext flag set while off");
endmodule // dtm_timer_sva

bind dtm_timer dtm_timer_sva u_sva (.REF_CLK, .RST, .SFR_ADDR, .SFR_WR, .SFR_WDATA, .SFR_RD, .SFR_RDATA,
    .ACK_FLAG_ZERO, .ACK_FLAG_ONE, .OVERFLOW_FLAG_ZERO, .OVERFLOW_FLAG_ONE, .OVERFLOW_FLAG_TWO,
    .EXTERNAL_FLAG_TWO, .T1_OVF_PULSE, .T2_OVF_PULSE);

// ===== dv/test_dual_timer_with_capture_reload.sv
// testbench for the dual timer block, self-checking
// assumes: dtm_timer with 12-clock machine cycle, checker bound alongside
`timescale 1ns/100ps
module test_dual_timer_with_capture_reload;
    import dtm_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst     = 1'b1;
    logic [7:0]  addr    = 8'h00;
    logic [7:0]  wdat    = 8'h00;
    logic        wr_en   = 1'b0;
    logic        rd_en   = 1'b0;
    logic        ack0    = 1'b0;
    logic        ack1    = 1'b0;
    dtm_pins_s   pins    = 6'h3f;
    logic [7:0]  rdata;
    logic [5:0]  flags;
    int          num_errors = 0;
    int          n_tests    = 0;
    int          i;
    // rows: address, write data, read-back
    logic [23:0] rows [12] = '{24'h8a5555, 24'h8baaaa, 24'h8c3c3c, 24'h8dc3c3, 24'h89a5a5, 24'h880f00,
                              24'hca1111, 24'hcb2222, 24'hcc3333, 24'hcd4444, 24'h90ff00, 24'hc83030};

    always #12.5 ref_clk = ~ref_clk;

    dtm_timer dut (.REF_CLK(ref_clk), .RST(rst), .SFR_ADDR(addr), .SFR_WR(wr_en), .SFR_WDATA(wdat),
        .SFR_RD(rd_en), .SFR_RDATA(rdata), .PINS(pins), .ACK_FLAG_ZERO(ack0), .ACK_FLAG_ONE(ack1),
        .OVERFLOW_FLAG_ZERO(flags[0]), .OVERFLOW_FLAG_ONE(flags[1]), .OVERFLOW_FLAG_TWO(flags[2]),
        .EXTERNAL_FLAG_TWO(flags[3]), .T1_OVF_PULSE(flags[4]), .T2_OVF_PULSE(flags[5]));

    // ----------------------------------------
    // bus and pin tasks
    // ----------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdat  <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask
    // data lands on the edge that takes the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 check(rdata, exp);
    endtask
    // bounded wait; a stuck flag ends the run
    task automatic wait_flag(input int w);
        int k;
        for (k = 0; k < 400 && flags[w] !== 1'b1; k++) begin
            @(posedge ref_clk);
            #1;
        end
        if (k == 400) begin
            num_errors++;
            $display("MISMATCH t=%0t flag %0d never rose", $time, w);
            conclude();
        end
    endtask
    // falls spaced 9 clocks so the synchroniser sees each one
    task automatic cfall(input int n);
        repeat (n) begin
            @(posedge ref_clk) pins.t2_count_pin <= 1'b0;
            repeat (4) @(posedge ref_clk);
            pins.t2_count_pin <= 1'b1;
            repeat (4) @(posedge ref_clk);
        end
    endtask
    task automatic t0_start(input logic [7:0] m, input logic [7:0] th, input logic [7:0] tl);
        wr(8'h88, 8'h00);
        wr(8'h89, m);
        wr(8'h8c, th);
        wr(8'h8a, tl);
        wr(8'h88, 8'h10);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        rd(8'h8a, 8'h00);
        for (i = 0; i < 12; i++) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], rows[i][7:0]);
        end
        // gated 16-bit count, held by a low gate pin
        @(posedge ref_clk) pins.external_gate_pin_zero <= 1'b0;
        t0_start(8'h09, 8'hff, 8'hfe);
        repeat (30) @(posedge ref_clk);
        rd(8'h8a, 8'hfe);
        @(posedge ref_clk) pins.external_gate_pin_zero <= 1'b1;
        wait_flag(0);
        wr(8'h88, 8'h20);
        rd(8'h8a, 8'h00);
        rd(8'h8c, 8'h00);
        @(posedge ref_clk) ack0 <= 1'b1;
        @(posedge ref_clk) ack0 <= 1'b0;
        #1 check({7'h00, flags[0]}, 8'h00);
        // 13-bit: carry leaves the low five bits
        t0_start(8'h00, 8'hff, 8'hfe);
        wait_flag(0);
        wr(8'h88, 8'h20);
        rd(8'h8c, 8'h00);
        rd(8'h8a, 8'he0);
        t0_start(8'h02, 8'ha5, 8'hfe);
        wait_flag(0);
        wr(8'h88, 8'h20);
        rd(8'h8a, 8'ha5);
        rd(8'h8c, 8'ha5);
        // timer 1 parked in split mode, then auto-reload
        wr(8'h89, 8'h30);
        wr(8'h8b, 8'h10);
        wr(8'h88, 8'h40);
        repeat (40) @(posedge ref_clk);
        rd(8'h8b, 8'h10);
        wr(8'h89, 8'h20);
        wr(8'h8d, 8'h80);
        wr(8'h8b, 8'hff);
        wait_flag(1);
        rd(8'h8b, 8'h80);
        // split timer 0: high byte drives timer 1 flag
        wr(8'h88, 8'h40);
        wr(8'h89, 8'h03);
        wr(8'h8c, 8'hff);
        wait_flag(1);
        @(posedge ref_clk) ack1 <= 1'b1;
        @(posedge ref_clk) ack1 <= 1'b0;
        #1 check({7'h00, flags[1]}, 8'h00);
        wr(8'h88, 8'h00);
        // timer 2 capture on trigger fall, counting pin falls
        wr(8'hcc, 8'h34);
        wr(8'hcd, 8'h12);
        wr(8'hc8, 8'h0f);
        @(posedge ref_clk) pins.external_trigger_pin <= 1'b0;
        wait_flag(3);
        rd(8'hca, 8'h34);
        rd(8'hcb, 8'h12);
        cfall(3);
        rd(8'hcc, 8'h37);
        @(posedge ref_clk) pins.external_trigger_pin <= 1'b1;
        repeat (8) @(posedge ref_clk);
        wr(8'hc8, 8'h0e);
        wr(8'hcc, 8'hff);
        wr(8'hcd, 8'hff);
        @(posedge ref_clk) pins.external_trigger_pin <= 1'b0;
        wait_flag(3);
        rd(8'hcc, 8'h34);
        rd(8'hcd, 8'h12);
        wr(8'hcc, 8'hff);
        wr(8'hcd, 8'hff);
        cfall(1);
        check({7'h00, flags[2]}, 8'h01);
        rd(8'hcc, 8'h34);
        // baud generation: wrap without overflow flag
        wr(8'hc8, 8'h16);
        wr(8'hcc, 8'hff);
        wr(8'hcd, 8'hff);
        cfall(1);
        check({7'h00, flags[2]}, 8'h00);
        rd(8'hcc, 8'h34);
        @(posedge ref_clk) pins.external_trigger_pin <= 1'b1;
        repeat (8) @(posedge ref_clk);
        wr(8'hc8, 8'h1e);
        @(posedge ref_clk) pins.external_trigger_pin <= 1'b0;
        wait_flag(3);
        // second reset in mid-run
        @(posedge ref_clk) rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rd(8'h8c, 8'h00);
        check({2'h0, flags}, 8'h00);
        conclude();
    end
endmodule // test_dual_timer_with_capture_reload
